// >>> pasf_status_flags.sv
// alarm status and sticky flag registers with masked interrupt output
module pasf_status_flags (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // internal register port
   input wire pasf_pkg::pasf_req_type i_req,
   output logic [7:0] o_rdata,
   // live detector and pll state
   input wire pasf_pkg::pasf_live_type i_live,
   // masks and interrupt pin enable from the mask registers
   input wire pasf_pkg::pasf_mask_type i_mask,
   // interrupt output, active high
   output logic o_irq
);
   logic input_sig_lost_sticky;
   logic ref_sig_lost_sticky;
   logic lock_lost_sticky;
   logic clr_input;
   logic clr_ref;
   logic clr_lock;
   logic [7:0] next_rdata;
   logic next_irq;

   // only a written zero clears; a written one is ignored
   assign clr_input = i_req.wr && i_req.addr == pasf_pkg::ADDR_SIG_STICKY
      && !i_req.wdata[pasf_pkg::BIT_INPUT_STICKY];
   assign clr_ref = i_req.wr && i_req.addr == pasf_pkg::ADDR_SIG_STICKY
      && !i_req.wdata[pasf_pkg::BIT_REF_STICKY];
   assign clr_lock = i_req.wr && i_req.addr == pasf_pkg::ADDR_LOCK_STICKY
      && !i_req.wdata[pasf_pkg::BIT_LOCK_STICKY];

   pasf_sticky_bit u_input_sticky (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_reset_value(pasf_pkg::RESET_SIG_STICKY[pasf_pkg::BIT_INPUT_STICKY]),
      .i_live(i_live.input_sig_lost_live),
      .i_clear(clr_input),
      .o_flag(input_sig_lost_sticky)
   );

   pasf_sticky_bit u_ref_sticky (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_reset_value(pasf_pkg::RESET_SIG_STICKY[pasf_pkg::BIT_REF_STICKY]),
      .i_live(i_live.ref_sig_lost_live),
      .i_clear(clr_ref),
      .o_flag(ref_sig_lost_sticky)
   );

   pasf_sticky_bit u_lock_sticky (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_reset_value(pasf_pkg::RESET_LOCK_STICKY[pasf_pkg::BIT_LOCK_STICKY]),
      .i_live(i_live.lock_lost_live),
      .i_clear(clr_lock),
      .o_flag(lock_lost_sticky)
   );

   // read mux; reserved bits come from the reset images so they never change
   always_comb begin
      next_rdata = o_rdata;
      if (i_req.rd) begin
         if (i_req.addr == pasf_pkg::ADDR_LOCK_SKEW) begin
            next_rdata = pasf_pkg::RESET_LOCK_SKEW & 8'h7e;
            next_rdata[pasf_pkg::BIT_SKEW_BUSY] = i_live.skew_adjust_busy;
            next_rdata[pasf_pkg::BIT_LOCK_LIVE] = i_live.lock_lost_live;
         end else if (i_req.addr == pasf_pkg::ADDR_SIG_STICKY) begin
            next_rdata = pasf_pkg::RESET_SIG_STICKY & 8'hfc;
            next_rdata[pasf_pkg::BIT_INPUT_STICKY] = input_sig_lost_sticky;
            next_rdata[pasf_pkg::BIT_REF_STICKY] = ref_sig_lost_sticky;
         end else if (i_req.addr == pasf_pkg::ADDR_LOCK_STICKY) begin
            next_rdata = pasf_pkg::RESET_LOCK_STICKY & 8'hfd;
            next_rdata[pasf_pkg::BIT_LOCK_STICKY] = lock_lost_sticky;
         end else if (i_req.addr == pasf_pkg::ADDR_PART_HIGH) begin
            next_rdata = pasf_pkg::PART_NUMBER[11:4];
         end else if (i_req.addr == pasf_pkg::ADDR_PART_LOW_REV) begin
            next_rdata = {pasf_pkg::PART_NUMBER[3:0], pasf_pkg::REVISION};
         end else begin
            next_rdata = pasf_pkg::UNMAPPED_READ;
         end
      end
   end

   // read data holds until the next read request
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         // live lock bit reads unlocked, busy clear, before any read is made
         o_rdata <= pasf_pkg::RESET_LOCK_SKEW;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   assign next_irq = i_mask.irq_enable && (
      (input_sig_lost_sticky && !i_mask.input_sig_lost_mask)
      || (ref_sig_lost_sticky && !i_mask.ref_sig_lost_mask)
      || (lock_lost_sticky && !i_mask.lock_lost_mask));

   // registered, so the pin follows the flags one cycle later
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= next_irq;
      end
   end
endmodule : pasf_status_flags

// >>> pasf_pkg.sv
// package: register map, field positions and reset values of the alarm status group
// What this block does
// - Bit 7 of the lock and skew status register reads 1 while a coarse skew change is applied.
// - Bit 0 of the lock and skew status register reads 1 while the pll is unlocked.
// - After reset the lock and skew status register reads 0x01.
// - The input signal loss sticky flag in bit 1 latches on live input loss and holds until cleared.
// - A set input signal loss flag drives the interrupt when enabled and not masked.
// - The reference signal loss sticky flag in bit 0 latches on live reference loss and holds.
// - A set reference signal loss flag drives the interrupt when enabled and not masked.
// - The lock loss sticky flag in bit 1 latches on live lock loss and drives the interrupt.
// - Writing 0 to a sticky bit clears it and withdraws its interrupt contribution.
// - After reset the signal loss sticky register reads 0x1f.
// - After reset the lock loss sticky register reads 0x02.
// - Live input signal loss is 1 while the detector flags the selected input clock.
// - Live reference signal loss is 1 while the detector flags the reference input.
package pasf_pkg;
   localparam logic [7:0] ADDR_LOCK_SKEW = 8'h82;
   localparam logic [7:0] ADDR_SIG_STICKY = 8'h83;
   localparam logic [7:0] ADDR_LOCK_STICKY = 8'h84;
   localparam logic [7:0] ADDR_PART_HIGH = 8'h86;
   localparam logic [7:0] ADDR_PART_LOW_REV = 8'h87;
   localparam int BIT_SKEW_BUSY = 7;
   localparam int BIT_LOCK_LIVE = 0;
   localparam int BIT_INPUT_STICKY = 1;
   localparam int BIT_REF_STICKY = 0;
   localparam int BIT_LOCK_STICKY = 1;
   localparam logic [7:0] RESET_LOCK_SKEW = 8'h01;
   localparam logic [7:0] RESET_SIG_STICKY = 8'h1f;
   localparam logic [7:0] RESET_LOCK_STICKY = 8'h02;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // arbitrary identity values
   localparam logic [11:0] PART_NUMBER = 12'h5a5;
   localparam logic [3:0] REVISION = 4'h1;

   typedef struct packed {
      logic input_sig_lost_live;
      logic ref_sig_lost_live;
      logic lock_lost_live;
      logic skew_adjust_busy;
   } pasf_live_type;

   typedef struct packed {
      logic input_sig_lost_mask;
      logic ref_sig_lost_mask;
      logic lock_lost_mask;
      logic irq_enable;
   } pasf_mask_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pasf_req_type;
endpackage : pasf_pkg

// >>> pasf_sticky_bit.sv
// one held alarm flag: set by its live level, cleared by a written zero
module pasf_sticky_bit (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // control
   input wire logic i_reset_value,
   input wire logic i_live,
   input wire logic i_clear,
   // state
   output logic o_flag
);
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_flag <= i_reset_value;
      end else if (i_live) begin
         // set beats a clear in the same cycle so no event is lost
         o_flag <= 1'b1;
      end else if (i_clear) begin
         o_flag <= 1'b0;
      end
   end
endmodule : pasf_sticky_bit

// >>> pasf_chk.sv
// checker: read data and interrupt relations of the alarm group
module pasf_chk (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // watched ports
   input wire pasf_pkg::pasf_req_type i_req,
   input wire logic [7:0] o_rdata,
   input wire pasf_pkg::pasf_live_type i_live,
   input wire pasf_pkg::pasf_mask_type i_mask,
   input wire logic o_irq
);
   wire logic [7:0] a = i_req.addr;
   wire logic r = i_req.rd;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   chk_live_status: assert property (r && a == 8'h82 |=>
      o_rdata == {$past(i_live.skew_adjust_busy), 6'h00, $past(i_live.lock_lost_live)})
      else $error("live status read wrong");
   chk_sig_reserved: assert property (r && a == 8'h83 |=> o_rdata[7:2] == 6'h07)
      else $error("signal flag spare bits wrong");
   chk_lock_reserved: assert property (r && a == 8'h84 |=>
      o_rdata[7:2] == 6'h00 && !o_rdata[0]) else $error("lock flag spare bits wrong");
   chk_rdata_holds: assert property (!r |=> $stable(o_rdata)) else $error("read data moved");
   chk_irq_blocked: assert property (
      !i_mask.irq_enable || i_mask[3:1] == 3'b111 |=> !o_irq) else $error("blocked irq rose");
   chk_lock_irq: assert property (
      (i_mask.irq_enable && !i_mask.lock_lost_mask && i_live.lock_lost_live) [*2] |=> o_irq)
      else $error("lock loss irq missing");
   chk_ref_latch: assert property (i_live.ref_sig_lost_live ##1 (r && a == 8'h83)
      |=> o_rdata[0]) else $error("reference flag not held");
   chk_lock_clear: assert property (
      (i_req.wr && a == 8'h84 && !i_req.wdata[1] && !i_live.lock_lost_live) ##1
      (r && a == 8'h84 && !i_live.lock_lost_live) |=> !o_rdata[1]) else $error("no clear");
endmodule : pasf_chk
bind pasf_status_flags pasf_chk chk (.i_clk_sys, .i_reset, .i_req, .o_rdata, .i_live,
   .i_mask, .o_irq);

// >>> pasf_host.sv
// register host model: one request per clock, set at the falling edge
module pasf_host (
   // clock
   input wire logic i_clk_sys,
   // request
   output pasf_pkg::pasf_req_type o_req
);
   timeunit 1ns;
   timeprecision 1ns;
   initial o_req = '0;
   task xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk_sys);
      o_req = '{w, r, a, d};
   endtask : xfer
endmodule : pasf_host

// >>> tb_top.sv
// testbench: reads, clears and interrupt of the alarm group
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   pasf_pkg::pasf_req_type req;
   pasf_pkg::pasf_live_type live = 4'b0010;
   pasf_pkg::pasf_mask_type mask = 4'b1110;
   logic [7:0] rdata;
   logic irq;
   int mismatches = 0;
   int total_checks = 0;
   logic [7:0] adr [1:3] = '{8'h84, 8'h83, 8'h83};
   logic [7:0] set [1:3] = '{8'h02, 8'h1d, 8'h1e};
   logic [7:0] clr [1:3] = '{8'h00, 8'h1c, 8'h1c};
   pasf_host host (.i_clk_sys(i_clk_sys), .o_req(req));
   pasf_status_flags uut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(req),
      .o_rdata(rdata), .i_live(live), .i_mask(mask), .o_irq(irq));
   initial begin
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   task check(input logic [7:0] seen, input logic [7:0] want);
      total_checks++;
      if (seen !== want) begin
         mismatches++;
         $display("wrong value at %0t: %h %h", $time, seen, want);
      end
   endtask : check
   // read data lands on the edge that takes the strobe
   task rd(input logic [7:0] a, input logic [7:0] want);
      host.xfer(1'b0, 1'b1, a, 8'h00);
      host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
      check(rdata, want);
   endtask : rd
   task report_and_stop;
      if (mismatches == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (3) @(negedge i_clk_sys);
      i_reset = 1'b0;
      check(rdata, 8'h01);
      rd(8'h83, 8'h1f);
      rd(8'h84, 8'h02);
      live = 4'b0011;
      rd(8'h82, 8'h81);
      live = 4'b0000;
      rd(8'h82, 8'h00);
      host.xfer(1'b1, 1'b0, 8'h83, 8'hff);
      rd(8'h83, 8'h1f);
      host.xfer(1'b1, 1'b0, 8'h83, 8'h00);
      rd(8'h83, 8'h1c);
      host.xfer(1'b1, 1'b0, 8'h84, 8'h00);
      rd(8'h84, 8'h00);
      // a clear that meets a live loss must lose to the set
      live = 4'b0010;
      host.xfer(1'b1, 1'b0, 8'h84, 8'h00);
      rd(8'h84, 8'h02);
      live = 4'b0000;
      host.xfer(1'b1, 1'b0, 8'h84, 8'h00);
      rd(8'h84, 8'h00);
      host.xfer(1'b1, 1'b0, 8'h82, 8'hff);
      rd(8'h82, 8'h00);
      rd(8'h85, 8'h00);
      rd(8'h86, pasf_pkg::PART_NUMBER[11:4]);
      rd(8'h87, {pasf_pkg::PART_NUMBER[3:0], pasf_pkg::REVISION});
      mask = 4'b0001;
      for (int k = 1; k < 4; k++) begin
         live[k] = 1'b1;
         repeat (2) @(negedge i_clk_sys);
         rd(adr[k], set[k]);
         check({7'h00, irq}, 8'h01);
         mask[k] = 1'b1;
         repeat (2) @(negedge i_clk_sys);
         check({7'h00, irq}, 8'h00);
         mask[k] = 1'b0;
         live[k] = 1'b0;
         host.xfer(1'b1, 1'b0, adr[k], 8'h00);
         rd(adr[k], clr[k]);
         @(negedge i_clk_sys);
         check({7'h00, irq}, 8'h00);
      end
      report_and_stop();
   end
endmodule : tb_top
